/* File: hw/anpr_regs.sv */
/*
 * anpr_regs: partner base page upper word and the transmit next page words of the
 * autonegotiation unit, reached by the management register port in device 0x07.
 * Assumes the management front end delivers one-cycle read and write strobes with
 * device and register address, and the arbitration machine runs on the same clock.
 */
// Notes on behaviour
// - registers sit in device 7, 0x0207 to 0x020A
// - partner upper word held on low-word read
// - upper word read returns held copy
// - bit 14 reports partner energy saving ability
// - bit 13 reports partner high level ability
// - bit 12 reports partner high level request
// - bit 11 reports partner short-reach half duplex
// - reset loads 0x2001, mid and high zero; partner copy zeroed by rst_in only
// - bit 15 writable more-pages request, reset 0
// - bit 14 read-only acknowledge from arbitration
// - bit 13 writable encoding select, reset 1
// - bit 12 writable comply acknowledge, reset 0
// - bit 11 reads zero, toggle inserted later
// - code field writable, resets to null code
// - mid word fully writable, resets zero
// - high word fully writable, resets zero
`timescale 1ns/1ps
`default_nettype none

module anpr_regs
	import anpr_pkg::*;
(
	input  wire logic        core_clk_in,                 // system clock, 10 MHz
	input  wire logic        rst_in,                      // synchronous reset, high
	input  wire logic        an_reset_in,                 // autonegotiation reset pulse
	input  wire logic [4:0]  mgmt_dev_in,                 // management device address
	input  wire logic [15:0] mgmt_addr_in,                // register address
	input  wire logic        mgmt_rd_in,                  // read strobe
	input  wire logic        mgmt_wr_in,                  // write strobe
	input  wire logic [15:0] mgmt_wdata_in,               // write data
	output logic      [15:0] mgmt_rdata_out,              // read data
	output logic             mgmt_rvalid_out,             // read data valid pulse
	input  wire logic        partner_low_read_in,         // partner low word being read
	input  wire logic [15:0] partner_base_page_upper_in,  // live partner bits 47:32
	input  wire logic        page_acknowledge_in,         // ack from arbitration
	output logic      [47:0] tx_page_out,                 // committed next page
	output logic             tx_page_commit_out,          // page committed pulse
	output logic             more_pages_request_out,      // committed more-pages bit
	output logic             partner_high_level_use_out   // partner able and asking
);

	typedef struct packed {
		logic [15:0] rdata;
		logic        rvalid;
		logic        more_pages_request;
		logic        page_acknowledge;
		logic        page_encoding_select;
		logic        comply_acknowledge;
		logic [10:0] page_code_field;
		logic [15:0] free_code_field_one;
		logic [15:0] free_code_field_two;
		logic [47:0] page;
		logic        commit;
	} anpr_state_t;

	localparam anpr_state_t ANPR_STATE_RESET = '{
		rdata:                16'h0000,
		rvalid:               1'b0,
		more_pages_request:   ANPR_TX_LOW_RESET[ANPR_NP_MORE],
		page_acknowledge:     ANPR_TX_LOW_RESET[ANPR_NP_ACK],
		page_encoding_select: ANPR_TX_LOW_RESET[ANPR_NP_ENCODING],
		comply_acknowledge:   ANPR_TX_LOW_RESET[ANPR_NP_ACK2],
		page_code_field:      ANPR_TX_LOW_RESET[ANPR_NP_CODE_MSB:0],
		free_code_field_one:  ANPR_TX_MID_RESET,
		free_code_field_two:  ANPR_TX_HIGH_RESET,
		page:                 {ANPR_TX_HIGH_RESET, ANPR_TX_MID_RESET, ANPR_TX_LOW_RESET},
		commit:               1'b0
	};

	anpr_state_t state_reg;
	anpr_state_t state_next;
	anpr_sel_t   rd_sel;
	anpr_sel_t   wr_sel;
	logic [15:0] partner_held;
	logic [15:0] tx_low_word;

	////////////////////////////////////////////////////////////////////////////////
	// address decode, shared by read and write paths

	function automatic anpr_sel_t decode_sel(
		input logic [4:0]  dev,
		input logic [15:0] addr
	);
		anpr_sel_t sel;
		sel = ANPR_SEL_NONE;
		if (dev == ANPR_DEV_ADDR)
		begin
			case (addr)
				ANPR_OFS_PARTNER_UPR: sel = ANPR_SEL_PARTNER;
				ANPR_OFS_TX_LOW:      sel = ANPR_SEL_LOW;
				ANPR_OFS_TX_MID:      sel = ANPR_SEL_MID;
				ANPR_OFS_TX_HIGH:     sel = ANPR_SEL_HIGH;
				default:              sel = ANPR_SEL_NONE;
			endcase
		end
		return sel;
	endfunction

	// low word image; toggle always zero here, the arbitration machine sets it on the wire
	function automatic logic [15:0] pack_low(
		input logic        more,
		input logic        ack,
		input logic        enc,
		input logic        ack2,
		input logic [10:0] code
	);
		logic [15:0] word;
		word                          = 16'h0000;
		word[ANPR_NP_MORE]            = more;
		word[ANPR_NP_ACK]             = ack;
		word[ANPR_NP_ENCODING]        = enc;
		word[ANPR_NP_ACK2]            = ack2;
		word[ANPR_NP_TOGGLE]          = 1'b0;
		word[ANPR_NP_CODE_MSB:0]      = code;
		return word;
	endfunction

	assign rd_sel = mgmt_rd_in ? decode_sel(mgmt_dev_in, mgmt_addr_in) : ANPR_SEL_NONE;
	assign wr_sel = mgmt_wr_in ? decode_sel(mgmt_dev_in, mgmt_addr_in) : ANPR_SEL_NONE;

	assign tx_low_word = pack_low(state_reg.more_pages_request, state_reg.page_acknowledge,
		state_reg.page_encoding_select, state_reg.comply_acknowledge, state_reg.page_code_field);

	////////////////////////////////////////////////////////////////////////////////
	// partner base page upper word, frozen while software walks the page

	anpr_hold #(
		.WIDTH (16),
		.RESET (ANPR_PARTNER_RESET)
	) u_partner_hold (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.capture_in  (partner_low_read_in),
		.data_in     (partner_base_page_upper_in & ANPR_PARTNER_MASK),
		.data_out    (partner_held)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_next        = state_reg;
		state_next.rvalid = 1'b0;
		state_next.commit = 1'b0;

		// ack follows the arbitration machine, software cannot write it
		state_next.page_acknowledge = page_acknowledge_in;

		// read returns the value before any same-cycle write
		case (rd_sel)
			ANPR_SEL_PARTNER:
			begin
				state_next.rvalid = 1'b1;
				state_next.rdata  = partner_held;
			end
			ANPR_SEL_LOW:
			begin
				state_next.rvalid = 1'b1;
				state_next.rdata  = tx_low_word;
			end
			ANPR_SEL_MID:
			begin
				state_next.rvalid = 1'b1;
				state_next.rdata  = state_reg.free_code_field_one;
			end
			ANPR_SEL_HIGH:
			begin
				state_next.rvalid = 1'b1;
				state_next.rdata  = state_reg.free_code_field_two;
			end
			default:
			begin
				state_next.rdata  = 16'h0000;
			end
		endcase

		case (wr_sel)
			ANPR_SEL_LOW:
			begin
				// bits 14 and 11 are not stored from software
				state_next.more_pages_request   = mgmt_wdata_in[ANPR_NP_MORE];
				state_next.page_encoding_select = mgmt_wdata_in[ANPR_NP_ENCODING];
				state_next.comply_acknowledge   = mgmt_wdata_in[ANPR_NP_ACK2];
				state_next.page_code_field      = mgmt_wdata_in[ANPR_NP_CODE_MSB:0];
				// low write seals the page from the mid and high words written before
				state_next.page   = {state_reg.free_code_field_two, state_reg.free_code_field_one,
					pack_low(mgmt_wdata_in[ANPR_NP_MORE], 1'b0, mgmt_wdata_in[ANPR_NP_ENCODING],
					mgmt_wdata_in[ANPR_NP_ACK2], mgmt_wdata_in[ANPR_NP_CODE_MSB:0])};
				state_next.commit = 1'b1;
			end
			ANPR_SEL_MID:
			begin
				state_next.free_code_field_one = mgmt_wdata_in;
			end
			ANPR_SEL_HIGH:
			begin
				state_next.free_code_field_two = mgmt_wdata_in;
			end
			default:
			begin
				// partner word is read-only, writes fall away
				state_next.commit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in || an_reset_in)
		begin
			state_reg <= ANPR_STATE_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign mgmt_rdata_out             = state_reg.rdata;
	assign mgmt_rvalid_out            = state_reg.rvalid;
	assign tx_page_out                = state_reg.page;
	assign tx_page_commit_out         = state_reg.commit;
	assign more_pages_request_out     = state_reg.page[ANPR_NP_MORE];
	// level choice uses the held copy, so it matches what software last saw
	assign partner_high_level_use_out = partner_held[ANPR_PB_HI_CAPABLE] &
		partner_held[ANPR_PB_HI_REQUEST];

endmodule

`default_nettype wire

/* File: common/anpr_pkg.sv */
/*
 * anpr_pkg: constants shared by the autonegotiation next page register slice.
 * Assumes clause-45 style access: a 5-bit device address plus a 16-bit register address.
 */
`default_nettype none

package anpr_pkg;

	// management device and register addresses
	localparam logic [4:0]  ANPR_DEV_ADDR        = 5'h07;
	localparam logic [15:0] ANPR_OFS_PARTNER_UPR = 16'h0207;
	localparam logic [15:0] ANPR_OFS_TX_LOW      = 16'h0208;
	localparam logic [15:0] ANPR_OFS_TX_MID      = 16'h0209;
	localparam logic [15:0] ANPR_OFS_TX_HIGH     = 16'h020A;

	// reset values
	localparam logic [15:0] ANPR_PARTNER_RESET   = 16'h0000;
	localparam logic [15:0] ANPR_TX_LOW_RESET    = 16'h2001;
	localparam logic [15:0] ANPR_TX_MID_RESET    = 16'h0000;
	localparam logic [15:0] ANPR_TX_HIGH_RESET   = 16'h0000;

	// partner base page upper word fields
	localparam int          ANPR_PB_EEE          = 14;
	localparam int          ANPR_PB_HI_CAPABLE   = 13;
	localparam int          ANPR_PB_HI_REQUEST   = 12;
	localparam int          ANPR_PB_SHORT_HD     = 11;
	localparam logic [15:0] ANPR_PARTNER_MASK    = 16'h7800;

	// transmit next page low word fields
	localparam int          ANPR_NP_MORE         = 15;
	localparam int          ANPR_NP_ACK          = 14;
	localparam int          ANPR_NP_ENCODING     = 13;
	localparam int          ANPR_NP_ACK2         = 12;
	localparam int          ANPR_NP_TOGGLE       = 11;
	localparam int          ANPR_NP_CODE_MSB     = 10;
	localparam int          ANPR_CODE_W          = 11;

	// message codes
	localparam logic [10:0] ANPR_CODE_NULL       = 11'h001;
	localparam logic [10:0] ANPR_CODE_VENDOR_TAG = 11'h005;
	localparam logic [10:0] ANPR_CODE_DEVICE_TAG = 11'h006;

	typedef enum {
		ANPR_SEL_NONE,
		ANPR_SEL_PARTNER,
		ANPR_SEL_LOW,
		ANPR_SEL_MID,
		ANPR_SEL_HIGH
	} anpr_sel_t;

endpackage

`default_nettype wire

/* File: hw/anpr_hold.sv */
/*
 * anpr_hold: holding copy of a word, loaded on a one-cycle capture strobe.
 * Assumes data and strobe come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module anpr_hold #(
	parameter int                 WIDTH = 16,
	parameter logic [WIDTH-1:0]   RESET = '0
) (
	input  wire logic             core_clk_in,  // system clock
	input  wire logic             rst_in,       // synchronous reset, high
	input  wire logic             capture_in,   // load strobe
	input  wire logic [WIDTH-1:0] data_in,      // live word
	output logic      [WIDTH-1:0] data_out      // held word
);

	typedef struct packed {
		logic [WIDTH-1:0] held;
	} anpr_hold_state_t;

	anpr_hold_state_t state_reg;
	anpr_hold_state_t state_next;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_next = state_reg;
		if (capture_in)
		begin
			state_next.held = data_in;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state_reg.held <= RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign data_out = state_reg.held;

endmodule

`default_nettype wire

/* File: tb/anpr_regs_monitor.sv */
/* anpr_regs_monitor: port-level checks of the next page register slice.
   Assumes one clock domain and a bind onto every anpr_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module anpr_regs_monitor (
	input wire logic        core_clk_in,                // clock
	input wire logic        rst_in,                     // sync reset
	input wire logic        an_reset_in,                // autoneg reset
	input wire logic [4:0]  mgmt_dev_in,                // device
	input wire logic [15:0] mgmt_addr_in,               // address
	input wire logic        mgmt_rd_in,                 // read strobe
	input wire logic        mgmt_wr_in,                 // write strobe
	input wire logic [15:0] mgmt_wdata_in,              // write data
	input wire logic [15:0] mgmt_rdata_out,             // read data
	input wire logic        mgmt_rvalid_out,            // read valid
	input wire logic        partner_low_read_in,        // capture strobe
	input wire logic [15:0] partner_base_page_upper_in, // live word
	input wire logic [47:0] tx_page_out,                // committed page
	input wire logic        tx_page_commit_out,         // commit pulse
	input wire logic        more_pages_request_out      // more pages
);
wire logic dv = mgmt_dev_in == 5'h07 && !an_reset_in;
wire logic in_rng = mgmt_addr_in >= 16'h0207 && mgmt_addr_in <= 16'h020A;
default clocking cb @(posedge core_clk_in); endclocking
default disable iff (rst_in);
////////////////////////////////////////////////////////////////
sequence s_wr(logic [15:0] a);
	mgmt_wr_in && dv && mgmt_addr_in == a;
endsequence
sequence s_page;
	s_wr(16'h0209) ##1 s_wr(16'h020A) ##1 s_wr(16'h0208);
endsequence
sequence s_cap;
	partner_low_read_in ##1 !partner_low_read_in ##1
	(mgmt_rd_in && dv && mgmt_addr_in == 16'h0207 && !partner_low_read_in);
endsequence
property p_rd_hit; mgmt_rd_in && dv && in_rng |=> mgmt_rvalid_out; endproperty
property p_rd_miss;
	!an_reset_in && !(mgmt_rd_in && dv && in_rng) |=> !mgmt_rvalid_out && mgmt_rdata_out == 16'h0000;
endproperty
property p_commit;
	s_wr(16'h0208) |=> tx_page_commit_out && tx_page_out[15:0] == ($past(mgmt_wdata_in) & 16'hB7FF);
endproperty
property p_page; s_page |=> tx_page_out[47:16] == {$past(mgmt_wdata_in, 2), $past(mgmt_wdata_in, 3)}; endproperty
property p_reset; rst_in || an_reset_in |=> tx_page_out == 48'h0000_0000_2001 && !tx_page_commit_out; endproperty
property p_stable; !tx_page_commit_out && !$past(an_reset_in) |-> $stable(tx_page_out); endproperty
// expected bit comes from the written word, not from the committed page
property p_more;
	s_wr(16'h0208) |=> more_pages_request_out == (($past(mgmt_wdata_in) & 16'h8000) != 16'h0000);
endproperty
property p_hold; s_cap |=> mgmt_rdata_out == ($past(partner_base_page_upper_in, 3) & 16'h7800); endproperty
a_rd_hit: assert property (p_rd_hit) else $error("read not answered");
a_rd_miss: assert property (p_rd_miss) else $error("stray read valid");
a_commit: assert property (p_commit) else $error("low word commit wrong");
a_page: assert property (p_page) else $error("page words wrong");
a_reset: assert property (p_reset) else $error("page not reset");
a_stable: assert property (p_stable) else $error("page moved without commit");
a_more: assert property (p_more) else $error("more pages mismatch");
a_hold: assert property (p_hold) else $error("held upper word wrong");
endmodule
bind anpr_regs anpr_regs_monitor anpr_regs_monitor_i (.*);
`default_nettype wire

/* File: tb/anpr_host.sv */
/* anpr_host: management host model with one-cycle strobes.
   Assumes the caller serialises calls; released address and data lines show inverted values. */
`timescale 1ns/1ps
`default_nettype none
module anpr_host (
	input  wire logic        core_clk_in, // clock
	input  wire logic [15:0] rdata_in,    // read data
	input  wire logic        rvalid_in,   // read valid
	output logic      [4:0]  dev_out,     // device
	output logic      [15:0] addr_out,    // address
	output logic             rd_out,      // read strobe
	output logic             wr_out,      // write strobe
	output logic      [15:0] wdata_out    // write data
);
initial
begin
	{dev_out, addr_out, rd_out, wr_out, wdata_out} = '0;
end
////////////////////////////////////////////////////////////////
// back to back, in list order: caller puts the low word last
task automatic wr(input int n, input logic [15:0] a [3], input logic [15:0] d [3]);
	for (int i = 0; i < n; i++)
	begin
		@(posedge core_clk_in);
		dev_out   <= 5'h07;
		addr_out  <= a[i];
		wdata_out <= d[i];
		wr_out    <= 1'b1;
	end
	@(posedge core_clk_in);
	wr_out    <= 1'b0;
	addr_out  <= ~a[n-1];
	wdata_out <= ~d[n-1];
endtask
task automatic rd(input logic [4:0] dv, input logic [15:0] a, output logic [15:0] q, output logic v);
	@(posedge core_clk_in);
	dev_out  <= dv;
	addr_out <= a;
	rd_out   <= 1'b1;
	@(posedge core_clk_in);
	rd_out   <= 1'b0;
	addr_out <= ~a;
	#1;
	q = rdata_in;
	v = rvalid_in;
endtask
endmodule
`default_nettype wire

/* File: tb/test_autoneg_next_page_regs.sv */
/* test_autoneg_next_page_regs: directed register tests of anpr_regs.
   Assumes anpr_host for management cycles and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module test_autoneg_next_page_regs;
logic        core_clk_in = 1'b0;
logic        rst_in = 1'b1;
logic        an_reset_in = 1'b0;
logic        partner_low_read_in = 1'b0;
logic        page_acknowledge_in = 1'b0;
logic [15:0] partner_base_page_upper_in = 16'h0000;
logic [4:0]  mgmt_dev_in;
logic [15:0] mgmt_addr_in, mgmt_wdata_in, mgmt_rdata_out, q, lo, pv [2];
logic        mgmt_rd_in, mgmt_wr_in, mgmt_rvalid_out, v;
logic        tx_page_commit_out, more_pages_request_out, partner_high_level_use_out;
logic [47:0] tx_page_out;
int          n_mismatch = 0;
int          check_count = 0;
always #50 core_clk_in = ~core_clk_in;
anpr_regs anpr_regs_i (.*);
anpr_host anpr_host_i (.core_clk_in(core_clk_in), .rdata_in(mgmt_rdata_out), .rvalid_in(mgmt_rvalid_out),
	.dev_out(mgmt_dev_in), .addr_out(mgmt_addr_in), .rd_out(mgmt_rd_in), .wr_out(mgmt_wr_in),
	.wdata_out(mgmt_wdata_in));
////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
	check_count++;
	if (seen !== exp)
	begin
		n_mismatch++;
		$display("FAIL %s expected %h seen %h", nm, exp, seen);
	end
endtask
task automatic rdc(input logic [15:0] a, input logic [15:0] e);
	anpr_host_i.rd(5'h07, a, q, v);
	chk("rvalid", v, 1'b1);
	chk("rdata", q, e);
endtask
task automatic end_of_test;
	$display("checks %0d mismatches %0d", check_count, n_mismatch);
	if (n_mismatch == 0 && check_count > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
////////////////////////////////////////////////////////////////
initial
begin
	#(100 * 3000);
	n_mismatch++;
	end_of_test();
end
initial
begin
	repeat (6) @(posedge core_clk_in);
	rst_in <= 1'b0;
	rdc(16'h0207, 16'h0000);
	rdc(16'h0208, 16'h2001);
	rdc(16'h0209, 16'h0000);
	rdc(16'h020A, 16'h0000);
	chk("more", more_pages_request_out, 1'b0);
	anpr_host_i.rd(5'h01, 16'h0208, q, v);
	chk("rvalid", v, 1'b0);
	anpr_host_i.rd(5'h07, 16'h020B, q, v);
	chk("rvalid", v, 1'b0);
	anpr_host_i.wr(1, '{16'h0207, 16'h0000, 16'h0000}, '{16'hFFFF, 16'h0000, 16'h0000});
	rdc(16'h0207, 16'h0000);
	// null, vendor tag, device tag; written ack and toggle must drop out
	for (int i = 0; i < 3; i++)
	begin
		lo = {2'b11, i[0], ~i[0], 1'b1, (i == 0) ? 11'h001 : (i == 1) ? 11'h005 : 11'h006};
		anpr_host_i.wr(3, '{16'h0209, 16'h020A, 16'h0208}, '{{8'hA5, 8'(i)}, {8'h5A, 8'(i)}, lo});
		#1;
		chk("commit", tx_page_commit_out, 1'b1);
		chk("tx_page", tx_page_out, {8'h5A, 8'(i), 8'hA5, 8'(i), lo & 16'hB7FF});
		chk("more", more_pages_request_out, 1'b1);
		rdc(16'h0208, lo & 16'hB7FF);
	end
	@(posedge core_clk_in) page_acknowledge_in <= 1'b1;
	rdc(16'h0208, (lo & 16'hB7FF) | 16'h4000);
	pv = '{16'hFFFF, 16'h2800};
	for (int j = 0; j < 2; j++)
	begin
		@(posedge core_clk_in);
		partner_base_page_upper_in <= pv[j];
		partner_low_read_in        <= 1'b1;
		@(posedge core_clk_in);
		partner_low_read_in        <= 1'b0;
		partner_base_page_upper_in <= ~pv[j];
		rdc(16'h0207, pv[j] & 16'h7800);
		chk("high_level_use", partner_high_level_use_out, j == 0);
	end
	anpr_host_i.wr(1, '{16'h0209, 16'h0000, 16'h0000}, '{16'h1234, 16'h0000, 16'h0000});
	// mid word must really hold data before the reset check means anything
	rdc(16'h0209, 16'h1234);
	@(posedge core_clk_in) an_reset_in <= 1'b1;
	@(posedge core_clk_in) an_reset_in <= 1'b0;
	rdc(16'h0209, 16'h0000);
	rdc(16'h0208, 16'h6001);
	chk("tx_page", tx_page_out, 48'h0000_0000_2001);
	rdc(16'h0207, 16'h2800);
	end_of_test();
end
endmodule
`default_nettype wire
